// File: hw/wrw_pkg.sv
// Constants, types and state layout of the windowed reset watchdog
package wrw_pkg;

	// Register bus
	localparam int           WRW_AW          = 8;
	localparam int           WRW_DW          = 32;
	localparam logic [7:0]   WRW_IDX_CTRL    = 8'h2a;
	localparam logic [7:0]   WRW_IDX_CFG     = 8'h2e;
	localparam logic [7:0]   WRW_IDX_STAT    = 8'h2f;
	localparam logic [7:0]   WRW_ADDR_CTRL   = 8'(WRW_IDX_CTRL * 4);
	localparam logic [7:0]   WRW_ADDR_CFG    = 8'(WRW_IDX_CFG * 4);
	localparam logic [7:0]   WRW_ADDR_STAT   = 8'(WRW_IDX_STAT * 4);
	localparam logic [1:0]   WRW_RESP_OKAY   = 2'h0;
	localparam logic [1:0]   WRW_RESP_SLVERR = 2'h2;

	// Control register fields and reset values
	localparam int           WRW_ACT_BIT     = 7;
	localparam int           WRW_CNT_W       = 7;
	localparam logic [6:0]   WRW_CNT_RST     = 7'h7f;
	localparam logic         WRW_ACT_RST     = 1'h0;
	localparam logic [6:0]   WRW_CNT_TRIP    = 7'h40;

	// Configuration and status fields
	localparam int           WRW_CFG_DLY_BIT = 0;
	localparam logic         WRW_DLY_LONG_RST = 1'h0;
	localparam int           WRW_ST_ACT_BIT  = 0;
	localparam int           WRW_ST_HALT_BIT = 1;
	localparam int           WRW_ST_AHLT_BIT = 2;
	localparam int           WRW_ST_DLY_BIT  = 3;

	// Timing in clock cycles
	localparam int           WRW_PRESC_DEF   = 16384;
	localparam int           WRW_PRESC_W     = 14;
	localparam int           WRW_DLY_SHORT   = 256;
	localparam int           WRW_DLY_LONG    = 4096;
	localparam int           WRW_DLY_W       = 12;

	typedef enum logic [2:0] {
		WRW_RUN,
		WRW_HALT_ONE,
		WRW_HALT_STOP,
		WRW_ACT_HALT,
		WRW_WAKE_DLY
	} wrw_mode_t;

	typedef struct packed {
		logic              awvalid;
		logic [WRW_AW-1:0] awaddr;
		logic              wvalid;
		logic [WRW_DW-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [WRW_AW-1:0] araddr;
		logic              rready;
	} wrw_axi_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [WRW_DW-1:0] rdata;
		logic [1:0]        rresp;
	} wrw_axi_rsp_t;

	typedef struct packed {
		wrw_mode_t              mode;
		logic [WRW_CNT_W-1:0]   cnt;
		logic                   act;
		logic                   dly_long;
		logic [WRW_PRESC_W-1:0] presc;
		logic [WRW_DLY_W-1:0]   dly;
		logic                   rst;
		logic                   aw_got;
		logic [WRW_AW-1:0]      awaddr;
		logic                   w_got;
		logic [WRW_DW-1:0]      wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [WRW_DW-1:0]      rdata;
		logic [1:0]             rresp;
	} wrw_state_t;

endpackage

// File: hw/wrw_watchdog.sv
// Windowed reset watchdog with AXI4-Lite register slave
`timescale 1ns/1ps

// Overview of operation
// [R1] Plain halt: no reset, one more decrement, then stop until wake or reset
// [R2] External interrupt ends plain halt: counting resumes after 256/4096 cycles
// [R3] Reset ending halt restores disabled reset state unless hardware option
// [R4] Halt with halt-reset option, active watchdog and oscillator interrupt disabled resets at once
// [R5] Halt with oscillator interrupt enabled: active-halt, counter frozen
// [R6] Oscillator or external interrupt ends active-halt: count resumes at once
// [R7] Reset ending active-halt: counting resumes after 256/4096 cycles
// [R8] Hardware option keeps watchdog active, activation bit ignored
// [R9] Software should refresh the counter just before halt
// [R10] Activation bit is bit 7, set by software, cleared only by reset
// [R11] Watchdog resets only while active: activation bit set or hardware option selected
// [R12] Seven-bit counter in bits 6:0 decrements every 16384 clocks
// [R13] Reset issued when active counter steps from 40h to 3Fh
// [R14] Control register resets to 7Fh
// [R15] Slow and wait modes do not affect the watchdog
// [R16] Writing the control register loads the counter
// [R17] Writing zero to the activation bit does nothing
module wrw_watchdog
	import wrw_pkg::*;
#(
	parameter int PRESC_CYCLES = WRW_PRESC_DEF
) (
	// Clock, reset, enable
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// AXI4-Lite slave
	input  wire wrw_axi_req_t axi_req,
	output wrw_axi_rsp_t      axi_rsp,
	// Option byte and clock controller
	input  wire logic         opt_hw_watchdog,
	input  wire logic         opt_halt_reset,
	input  wire logic         osc_irq_enable,
	// CPU power events, one-cycle pulses
	input  wire logic         halt_exec,
	input  wire logic         ext_irq_wake,
	input  wire logic         osc_irq_wake,
	input  wire logic         halt_exit_reset,
	// System side
	output logic              wdg_reset,
	output logic              wd_active
);

	localparam logic [WRW_PRESC_W-1:0] PRESC_LAST =
		WRW_PRESC_W'(PRESC_CYCLES - 1);

	wrw_state_t q;
	wrw_state_t d;
	logic       active;
	logic       tick;
	logic       wr_fire;
	logic       wr_ctrl;
	logic       wr_cfg;

	function automatic logic is_addr(input logic [WRW_AW-1:0] a,
		input logic [WRW_AW-1:0] reg_addr);
		is_addr = (a[WRW_AW-1:2] == reg_addr[WRW_AW-1:2]);
	endfunction

	function automatic logic is_mapped(input logic [WRW_AW-1:0] a);
		is_mapped = is_addr(a, WRW_ADDR_CTRL) || is_addr(a, WRW_ADDR_CFG) ||
			is_addr(a, WRW_ADDR_STAT);
	endfunction

	// Counter and activation back to their reset values
	function automatic wrw_state_t soft_reset(input wrw_state_t s);
		wrw_state_t r;
		r = s;
		r.cnt = WRW_CNT_RST;
		r.act = WRW_ACT_RST;
		r.presc = '0;
		return r;
	endfunction

	// Hold the counter for the selected wake-up delay
	function automatic wrw_state_t start_delay(input wrw_state_t s);
		wrw_state_t r;
		r = s;
		r.mode = WRW_WAKE_DLY;
		r.presc = '0;
		r.dly = s.dly_long ? WRW_DLY_W'(WRW_DLY_LONG - 1) :
			WRW_DLY_W'(WRW_DLY_SHORT - 1);
		return r;
	endfunction

	assign active = q.act | opt_hw_watchdog; // R8 R11
	assign tick = (q.presc == PRESC_LAST);
	assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
	assign wr_ctrl = wr_fire && q.wstrb[0] && is_addr(q.awaddr, WRW_ADDR_CTRL);
	assign wr_cfg = wr_fire && q.wstrb[0] && is_addr(q.awaddr, WRW_ADDR_CFG);

	always_comb begin
		d = q;
		d.rst = 1'h0;

		// Write channels are taken independently, answered when both are in
		if (axi_req.awvalid && axi_rsp.awready) begin
			d.aw_got = 1'h1;
			d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready) begin
			d.w_got = 1'h1;
			d.wdata = axi_req.wdata;
			d.wstrb = axi_req.wstrb;
		end
		if (q.bvalid && axi_req.bready) begin
			d.bvalid = 1'h0;
		end
		if (wr_fire) begin
			d.aw_got = 1'h0;
			d.w_got = 1'h0;
			d.bvalid = 1'h1;
			d.bresp = is_mapped(q.awaddr) ? WRW_RESP_OKAY : WRW_RESP_SLVERR;
		end

		if (q.rvalid && axi_req.rready) begin
			d.rvalid = 1'h0;
		end
		if (axi_req.arvalid && axi_rsp.arready) begin
			d.rvalid = 1'h1;
			d.rresp = WRW_RESP_OKAY;
			d.rdata = '0;
			if (is_addr(axi_req.araddr, WRW_ADDR_CTRL)) begin
				d.rdata[WRW_ACT_BIT] = q.act;
				d.rdata[WRW_CNT_W-1:0] = q.cnt;
			end else if (is_addr(axi_req.araddr, WRW_ADDR_CFG)) begin
				d.rdata[WRW_CFG_DLY_BIT] = q.dly_long;
			end else if (is_addr(axi_req.araddr, WRW_ADDR_STAT)) begin
				d.rdata[WRW_ST_ACT_BIT] = active;
				d.rdata[WRW_ST_HALT_BIT] = (q.mode == WRW_HALT_ONE) ||
					(q.mode == WRW_HALT_STOP);
				d.rdata[WRW_ST_AHLT_BIT] = (q.mode == WRW_ACT_HALT);
				d.rdata[WRW_ST_DLY_BIT] = (q.mode == WRW_WAKE_DLY);
			end else begin
				d.rresp = WRW_RESP_SLVERR;
			end
		end

		// Prescaler only runs while the counter may step
		if ((q.mode == WRW_RUN) || (q.mode == WRW_HALT_ONE)) begin
			d.presc = tick ? '0 : q.presc + 1'b1; // R12
		end

		case (q.mode)
			// Slow and wait never reach here as events; counting goes on
			WRW_RUN: begin // R15
				if (tick) begin
					d.cnt = q.cnt - 1'b1; // R12
					if (active && (q.cnt == WRW_CNT_TRIP)) begin
						d.rst = 1'h1; // R13 R11
					end
				end
				if (halt_exec) begin
					if (osc_irq_enable) begin
						d.mode = WRW_ACT_HALT; // R5
						d.cnt = q.cnt; // R5
					end else if (opt_halt_reset && active) begin
						d.rst = 1'h1; // R4
					end else begin
						d.mode = WRW_HALT_ONE; // R1
					end
				end
			end
			WRW_HALT_ONE: begin
				if (ext_irq_wake) begin
					d = start_delay(d); // R2
				end else if (halt_exit_reset) begin
					d = soft_reset(d); // R3
					d.mode = WRW_RUN;
				end else if (tick) begin
					// Last step before stopping never raises a reset
					d.cnt = q.cnt - 1'b1; // R1
					d.mode = WRW_HALT_STOP; // R1
				end
			end
			WRW_HALT_STOP: begin
				if (ext_irq_wake) begin
					d = start_delay(d); // R2
				end else if (halt_exit_reset) begin
					d = soft_reset(d); // R3
					d.mode = WRW_RUN;
				end
			end
			WRW_ACT_HALT: begin
				if (halt_exit_reset) begin
					d = soft_reset(d);
					d = start_delay(d); // R7
				end else if (osc_irq_wake || ext_irq_wake) begin
					d.mode = WRW_RUN; // R6
				end
			end
			WRW_WAKE_DLY: begin
				if (q.dly == '0) begin
					d.mode = WRW_RUN; // R2 R7
				end else begin
					d.dly = q.dly - 1'b1;
				end
			end
			default: begin
				d.mode = WRW_RUN;
			end
		endcase

		// A software refresh wins over a decrement in the same cycle
		if (wr_ctrl) begin
			d.cnt = q.wdata[WRW_CNT_W-1:0]; // R16
			if (q.wdata[WRW_ACT_BIT]) begin
				d.act = 1'h1; // R10 R17
			end
		end
		if (wr_cfg) begin
			d.dly_long = q.wdata[WRW_CFG_DLY_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.mode <= WRW_RUN;
			q.cnt <= WRW_CNT_RST; // R14
			q.act <= WRW_ACT_RST; // R14
			q.dly_long <= WRW_DLY_LONG_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// Each channel holds a single item; ready drops while one is pending
	always_comb begin
		axi_rsp.awready = !q.aw_got && !q.bvalid;
		axi_rsp.wready = !q.w_got && !q.bvalid;
		axi_rsp.bvalid = q.bvalid;
		axi_rsp.bresp = q.bresp;
		axi_rsp.arready = !q.rvalid;
		axi_rsp.rvalid = q.rvalid;
		axi_rsp.rdata = q.rdata;
		axi_rsp.rresp = q.rresp;
	end

	assign wdg_reset = q.rst;
	assign wd_active = active;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !ce);

	AST_HALT_NO_RESET: assert property ( // R1
		(q.mode == WRW_HALT_STOP) |=> !wdg_reset)
		else $error("reset raised while halted");

	AST_HALT_WAKE_DLY: assert property ( // R2
		(q.mode == WRW_HALT_STOP) && ext_irq_wake
		|=> (q.mode == WRW_WAKE_DLY) &&
			(q.dly == (q.dly_long ? WRW_DLY_W'(WRW_DLY_LONG - 1) :
			WRW_DLY_W'(WRW_DLY_SHORT - 1))))
		else $error("external wake from halt skipped the delay");

	AST_HALT_RESET_STATE: assert property ( // R3
		(q.mode == WRW_HALT_STOP) && !ext_irq_wake && halt_exit_reset &&
		!opt_hw_watchdog && !wr_ctrl
		|=> !wd_active && (q.cnt == WRW_CNT_RST) && (q.mode == WRW_RUN))
		else $error("reset from halt left watchdog enabled");

	AST_HALT_IMMED_RESET: assert property ( // R4
		(q.mode == WRW_RUN) && halt_exec && !osc_irq_enable &&
		opt_halt_reset && active |=> wdg_reset && (q.mode == WRW_RUN))
		else $error("halt with reset option did not reset");

	AST_ACT_HALT_FROZEN: assert property ( // R5
		(q.mode == WRW_ACT_HALT) && !wr_ctrl && !halt_exit_reset
		|=> $stable(q.cnt) && !wdg_reset)
		else $error("counter moved in active-halt");

	AST_ACT_HALT_RESUME: assert property ( // R6
		(q.mode == WRW_ACT_HALT) && !halt_exit_reset &&
		(osc_irq_wake || ext_irq_wake) |=> (q.mode == WRW_RUN))
		else $error("active-halt wake did not resume at once");

	AST_ACT_HALT_RST_DLY: assert property ( // R7
		(q.mode == WRW_ACT_HALT) && halt_exit_reset && !q.dly_long && !wr_cfg
		|=> (q.mode == WRW_WAKE_DLY) ##255 (q.mode == WRW_WAKE_DLY)
		##1 (q.mode == WRW_RUN))
		else $error("reset wake from active-halt delay is wrong");

	AST_HW_ACTIVE: assert property ( // R8
		opt_hw_watchdog && !q.act && (q.mode == WRW_RUN) && tick &&
		(q.cnt == WRW_CNT_TRIP) |=> wdg_reset)
		else $error("hardware option did not force a trip");

	AST_ACT_STICKY: assert property ( // R10
		q.act && !halt_exit_reset |=> q.act)
		else $error("activation bit cleared without reset");

	AST_DISABLED_QUIET: assert property ( // R11
		!active && !wr_ctrl |=> !wdg_reset)
		else $error("reset raised while disabled");

	AST_STEP_RATE: assert property ( // R12
		(q.mode == WRW_RUN) && tick && !wr_ctrl && !halt_exec
		|=> q.cnt == $past(q.cnt) - 1'b1)
		else $error("counter did not step on prescaler tick");

	AST_UNDERFLOW: assert property ( // R13
		(q.mode == WRW_RUN) && tick && active && (q.cnt == WRW_CNT_TRIP)
		|=> wdg_reset)
		else $error("underflow from 40h gave no reset");

	AST_REFRESH: assert property ( // R16
		wr_ctrl |=> (q.cnt == $past(q.wdata[WRW_CNT_W-1:0])) && q.bvalid)
		else $error("control write did not load the counter");

	AST_HALT_ONE_STEP: assert property ( // R1
		(q.mode == WRW_HALT_ONE) && tick && !ext_irq_wake &&
		!halt_exit_reset && !wr_ctrl
		|=> (q.mode == WRW_HALT_STOP) && (q.cnt == $past(q.cnt) - 1'b1))
		else $error("plain halt did not take its last step");

	AST_HALT_STOP_HOLD: assert property ( // R1
		(q.mode == WRW_HALT_STOP) && !ext_irq_wake && !halt_exit_reset &&
		!wr_ctrl |=> $stable(q.cnt) && (q.mode == WRW_HALT_STOP))
		else $error("counter moved after halt stopped it");

	AST_DLY_HOLD: assert property ( // R2 R7
		(q.mode == WRW_WAKE_DLY) && !wr_ctrl |=> $stable(q.cnt) && !wdg_reset)
		else $error("counter moved during wake delay");

	AST_DLY_EXIT: assert property ( // R2 R7
		(q.mode == WRW_WAKE_DLY) && (q.dly == '0) |=> (q.mode == WRW_RUN))
		else $error("wake delay did not end");

	AST_ACT_SET: assert property ( // R10
		wr_ctrl && q.wdata[WRW_ACT_BIT] |=> q.act)
		else $error("write did not set the activation bit");

	COV_UNDERFLOW: cover property (
		(q.mode == WRW_RUN) && active && tick && (q.cnt == WRW_CNT_TRIP));
	COV_HALT_WAKE: cover property (
		(q.mode == WRW_HALT_STOP) ##1 (q.mode == WRW_WAKE_DLY));
	COV_ACT_HALT: cover property (
		(q.mode == WRW_ACT_HALT) ##1 (q.mode == WRW_RUN));
	COV_HALT_RESET: cover property (
		(q.mode == WRW_RUN) && halt_exec && opt_halt_reset && active &&
		!osc_irq_enable);

endmodule

// File: testbench/test_wrw_watchdog.sv
// Self-checking bench for the windowed reset watchdog
`timescale 1ns/1ps
module test_wrw_watchdog
	import wrw_pkg::*;
;
	logic         aclk      = 1'b0;
	logic         aresetn   = 1'b0;
	wrw_axi_req_t req       = '0;
	wrw_axi_rsp_t rsp;
	logic         hw_opt    = 1'b0;
	logic         halt_opt  = 1'b0;
	logic         osc_en    = 1'b0;
	// Halt, external wake, oscillator wake, halt-ending reset
	logic [3:0]   evs       = 4'h0;
	logic         wdg_reset;
	logic         wd_active;
	logic [31:0]  rv;
	logic [31:0]  a;
	logic [1:0]   rs;
	int           n;
	int           n_fail    = 0;
	int           n_checks  = 0;

	always #2 aclk = ~aclk;

	// Short prescaler keeps every counter step within a few cycles
	wrw_watchdog #(.PRESC_CYCLES(8)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.axi_req(req), .axi_rsp(rsp),
		.opt_hw_watchdog(hw_opt), .opt_halt_reset(halt_opt),
		.osc_irq_enable(osc_en), .halt_exec(evs[3]),
		.ext_irq_wake(evs[2]), .osc_irq_wake(evs[1]),
		.halt_exit_reset(evs[0]),
		.wdg_reset(wdg_reset), .wd_active(wd_active));

	task automatic results;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Waits as long as the slave needs; only the 20000-cycle bench timeout ends a hang
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		rs = 2'h3;
		req.awvalid <= 1'b1;
		req.awaddr  <= ad;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hf;
		req.bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		rs = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] ad);
		rs = 2'h3;
		rv = '0;
		req.arvalid <= 1'b1;
		req.araddr  <= ad;
		req.rready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rv = rsp.rdata;
		rs = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic pulse(input logic [3:0] v);
		evs <= v;
		@(posedge aclk);
		evs <= 4'h0;
		repeat (2) @(posedge aclk);
	endtask

	// Cycles until the reset request, or the limit if none comes
	task automatic wait_rst(input int lim);
		n = 0;
		while (n < lim && wdg_reset !== 1'b1) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task automatic do_reset;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	task automatic t_reset;
		do_reset();
		rd(WRW_ADDR_CTRL);
		chk(rv, 32'h0000007f);
		chk(wd_active, 1'b0);
		rd(8'h00);
		chk(rs, WRW_RESP_SLVERR);
		wr(8'h04, 32'h000000c1);
		chk(rs, WRW_RESP_SLVERR);
		wr(WRW_ADDR_CTRL, 32'h00000041);
		wait_rst(40);
		chk(n, 40);
		$display("t_reset done");
	endtask

	task automatic t_trip;
		do_reset();
		wr(WRW_ADDR_CTRL, 32'h000000c1);
		chk(wd_active, 1'b1);
		wait_rst(40);
		chk(n > 4 && n < 18, 1'b1);
		wr(WRW_ADDR_CTRL, 32'h00000000);
		rd(WRW_ADDR_CTRL);
		chk(rv[7], 1'b1);
		$display("t_trip done");
	endtask

	task automatic t_halt_rst;
		halt_opt <= 1'b1;
		do_reset();
		wr(WRW_ADDR_CTRL, 32'h000000f0);
		evs <= 4'h8;
		@(posedge aclk);
		evs <= 4'h0;
		@(posedge aclk);
		chk(wdg_reset, 1'b1);
		@(posedge aclk);
		chk(wdg_reset, 1'b0);
		rd(WRW_ADDR_STAT);
		chk(rv, 32'h00000001);
		$display("t_halt_rst done");
	endtask

	task automatic t_plain;
		halt_opt <= 1'b0;
		do_reset();
		wr(WRW_ADDR_CTRL, 32'h000000f0);
		pulse(4'h8);
		repeat (20) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		a = rv;
		chk(a[6:0] == 7'h6f || a[6:0] == 7'h6e, 1'b1);
		wait_rst(40);
		chk(n, 40);
		rd(WRW_ADDR_CTRL);
		chk(rv, a);
		pulse(4'h4);
		repeat (200) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv, a);
		repeat (100) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv[6:0] < a[6:0], 1'b1);
		pulse(4'h8);
		pulse(4'h1);
		rd(WRW_ADDR_CTRL);
		chk(rv, 32'h0000007f);
		chk(wd_active, 1'b0);
		$display("t_plain done");
	endtask

	task automatic t_active;
		osc_en   <= 1'b1;
		halt_opt <= 1'b1;
		do_reset();
		wr(WRW_ADDR_CTRL, 32'h000000f0);
		pulse(4'h8);
		rd(WRW_ADDR_CTRL);
		a = rv;
		wait_rst(40);
		chk(n, 40);
		rd(WRW_ADDR_CTRL);
		chk(rv, a);
		pulse(4'h2);
		repeat (8) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv[6:0] < a[6:0], 1'b1);
		pulse(4'h8);
		pulse(4'h1);
		rd(WRW_ADDR_CTRL);
		chk(rv, 32'h0000007f);
		repeat (200) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv, 32'h0000007f);
		repeat (100) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv[6:0] < 7'h7f, 1'b1);
		osc_en <= 1'b0;
		$display("t_active done");
	endtask

	// Long wake delay: counter must stay frozen well past the short one
	task automatic t_long;
		halt_opt <= 1'b0;
		do_reset();
		wr(WRW_ADDR_CFG, 32'h00000001);
		rd(WRW_ADDR_CFG);
		chk(rv, 32'h00000001);
		wr(WRW_ADDR_CTRL, 32'h000000f0);
		pulse(4'h8);
		repeat (10) @(posedge aclk);
		rd(WRW_ADDR_STAT);
		chk(rv, 32'h00000003);
		rd(WRW_ADDR_CTRL);
		a = rv;
		pulse(4'h4);
		rd(WRW_ADDR_STAT);
		chk(rv, 32'h00000009);
		repeat (4000) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv, a);
		repeat (200) @(posedge aclk);
		rd(WRW_ADDR_CTRL);
		chk(rv[6:0] < a[6:0], 1'b1);
		$display("t_long done");
	endtask

	// Hardware option must trip although the activation bit stays clear
	task automatic t_hw;
		halt_opt <= 1'b0;
		hw_opt   <= 1'b1;
		do_reset();
		chk(wd_active, 1'b1);
		wr(WRW_ADDR_CTRL, 32'h00000041);
		wait_rst(40);
		chk(n < 18, 1'b1);
		$display("t_hw done");
	endtask

	initial begin
		t_reset();
		t_trip();
		t_halt_rst();
		t_plain();
		t_active();
		t_long();
		t_hw();
		results();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		results();
	end
endmodule
